// ### hw/tcgen_top.sv
// Oscillator, system clock and timeout clock generator with its registers
`timescale 1ns/1ns
`default_nettype none
module tcgen_top #(
	parameter int unsigned TO_BASE = tcgen_pkg::TO_BASE_TICKS
) (
	input  wire logic                        clk_in,
	input  wire logic                        rst_n_in,
	input  wire logic [tcgen_pkg::ADDR_W-1:0] reg_addr_in,
	input  wire logic [tcgen_pkg::DATA_W-1:0] reg_wdata_in,
	input  wire logic                        reg_wr_in,
	input  wire logic                        reg_rd_in,
	input  wire logic                        update_pending_in,
	input  wire logic                        zero_cross_in,
	output var  logic [tcgen_pkg::DATA_W-1:0] reg_rdata_out,
	output var  logic                        system_clock_out,
	output var  logic                        timeout_clock_out,
	output var  logic                        timeout_tick_out,
	output var  logic                        update_apply_out
);
	import tcgen_pkg::*;

	logic             oscillator_enable_q;
	logic             timeout_clock_enable_q;
	logic             timeout_half_rate_select_q;
	logic             timeout_rate_times_four_q;
	logic             timeout_rate_divide_sixteen_q;
	logic [PER_W-1:0] to_period_q;
	logic [PER_W-1:0] to_period_d;
	logic [2:0]       to_shift;
	logic             to_run;

	tcgen_div_if #(.W(PER_W)) sys_if ();
	tcgen_div_if #(.W(PER_W)) to_if ();

	// Register writes
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			oscillator_enable_q <= RST_OSCILLATOR_ENABLE;
		end else if (reg_wr_in && reg_addr_in == ADDR_PWR_MGMT_1) begin
			oscillator_enable_q <= reg_wdata_in[BIT_OSCILLATOR_ENABLE];
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			timeout_clock_enable_q     <= RST_TO_ENA;
			timeout_half_rate_select_q <= RST_TO_HALF;
		end else if (reg_wr_in && reg_addr_in == ADDR_CLOCKING_1) begin
			timeout_clock_enable_q     <= reg_wdata_in[BIT_TO_ENA];
			timeout_half_rate_select_q <= reg_wdata_in[BIT_TO_HALF];
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			timeout_rate_times_four_q     <= RST_TO_X4;
			timeout_rate_divide_sixteen_q <= RST_TO_DIV16;
		end else if (reg_wr_in && reg_addr_in == ADDR_CLOCKING_4) begin
			timeout_rate_times_four_q     <= reg_wdata_in[BIT_TO_X4];
			timeout_rate_divide_sixteen_q <= reg_wdata_in[BIT_TO_DIV16];
		end
	end

	// Read back; unmapped addresses and spare bits read zero
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			reg_rdata_out <= '0;
		end else if (reg_rd_in) begin
			reg_rdata_out <= '0;
			case (reg_addr_in)
				ADDR_PWR_MGMT_1: begin
					reg_rdata_out[BIT_OSCILLATOR_ENABLE] <= oscillator_enable_q;
				end
				ADDR_CLOCKING_1: begin
					reg_rdata_out[BIT_TO_HALF] <= timeout_half_rate_select_q;
					reg_rdata_out[BIT_TO_ENA]  <= timeout_clock_enable_q;
				end
				ADDR_CLOCKING_4: begin
					reg_rdata_out[BIT_TO_DIV16] <= timeout_rate_divide_sixteen_q;
					reg_rdata_out[BIT_TO_X4]    <= timeout_rate_times_four_q;
				end
				default: begin
					reg_rdata_out <= '0;
				end
			endcase
		end
	end

	// Oscillator model: divides the fast clock to the nominal system rate
	assign sys_if.step   = oscillator_enable_q;
	assign sys_if.clear  = !oscillator_enable_q;
	assign sys_if.period = PER_W'(SYS_DIV);

	tcgen_div #(.W(PER_W)) u_sys_div (
		.clk_in   (clk_in),
		.rst_n_in (rst_n_in),
		.d        (sys_if.div)
	);

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			system_clock_out <= 1'b0;
		end else begin
			system_clock_out <= oscillator_enable_q && sys_if.half;
		end
	end

	// Timeout period in system clock ticks: base is the 1000Hz period
	assign to_shift = 3'(timeout_rate_times_four_q ? 0 : SHIFT_NO_X4)
		+ 3'(timeout_half_rate_select_q ? 0 : SHIFT_HALF)
		+ 3'(timeout_rate_divide_sixteen_q ? SHIFT_DIV16 : 0);
	assign to_period_d = PER_W'(TO_BASE) << to_shift;
	assign to_run      = oscillator_enable_q && timeout_clock_enable_q;

	// New rate taken only when idle or at a period boundary
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			to_period_q <= PER_W'(TO_BASE) << (SHIFT_NO_X4 + SHIFT_HALF);
		end else if (!to_run || to_if.wrap) begin
			to_period_q <= to_period_d;
		end
	end

	assign to_if.step   = to_run && sys_if.wrap;
	assign to_if.clear  = !to_run || to_if.wrap && to_period_q != to_period_d;
	assign to_if.period = to_period_q;

	tcgen_div #(.W(PER_W)) u_to_div (
		.clk_in   (clk_in),
		.rst_n_in (rst_n_in),
		.d        (to_if.div)
	);

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			timeout_clock_out <= 1'b0;
			timeout_tick_out  <= 1'b0;
		end else begin
			timeout_clock_out <= to_run && to_if.half;
			timeout_tick_out  <= to_run && to_if.wrap;
		end
	end

	// Pending volume update applies at zero cross or at timeout
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			update_apply_out <= 1'b0;
		end else begin
			update_apply_out <= update_pending_in && (zero_cross_in || to_run && to_if.wrap);
		end
	end

	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!rst_n_in);

	sequence s_cfg_taken;
		!to_run || to_if.wrap;
	endsequence

	chk_sys_off_low: assert property (!oscillator_enable_q |=> !system_clock_out)
		else $error("system clock active with oscillator off");
	chk_sys_tick_gap: assert property (sys_if.wrap |=> !sys_if.wrap [*8])
		else $error("system clock ticks too close");
	chk_to_off_quiet: assert property (!to_run |=> !timeout_clock_out && !timeout_tick_out)
		else $error("timeout clock active while disabled");
	chk_update_on_timeout: assert property (update_pending_in && to_run && to_if.wrap |=> update_apply_out)
		else $error("timeout did not apply pending update");
	chk_half_rate_div: assert property (s_cfg_taken ##0 (timeout_rate_times_four_q
		&& !timeout_half_rate_select_q && !timeout_rate_divide_sixteen_q)
		|=> to_period_q == PER_W'(2 * TO_BASE))
		else $error("half rate period wrong");
	chk_div16_rate: assert property (s_cfg_taken ##0 (timeout_rate_times_four_q
		&& timeout_half_rate_select_q && timeout_rate_divide_sixteen_q)
		|=> to_period_q == PER_W'(16 * TO_BASE))
		else $error("divide by sixteen period wrong");
	chk_rate_extremes: assert property (s_cfg_taken ##0 (!timeout_rate_times_four_q
		&& !timeout_half_rate_select_q && timeout_rate_divide_sixteen_q)
		|=> to_period_q == PER_W'(128 * TO_BASE))
		else $error("slowest period wrong");
	chk_period_glitch_free: assert property (!$stable(to_period_q) |-> !$past(to_run) || $past(to_if.wrap))
		else $error("timeout period changed mid cycle");
endmodule
`default_nettype wire

// ### hw/tcgen_pkg.sv
// Shared constants for the timeout clock generator
`default_nettype none
package tcgen_pkg;
	localparam int unsigned CLK_HZ          = 100_000_000;
	localparam int unsigned SYS_CLK_HZ      = 6_000_000;
	localparam int unsigned SYS_DIV         = (CLK_HZ + SYS_CLK_HZ / 2) / SYS_CLK_HZ;
	localparam int unsigned TO_FAST_US      = 1000;
	localparam int unsigned TO_BASE_TICKS   = (SYS_CLK_HZ / 1_000_000) * TO_FAST_US;
	localparam int unsigned ADDR_W          = 8;
	localparam int unsigned DATA_W          = 16;
	localparam int unsigned PER_W           = 20;
	localparam logic [7:0]  ADDR_PWR_MGMT_1 = 8'h01;
	localparam logic [7:0]  ADDR_CLOCKING_1 = 8'h06;
	localparam logic [7:0]  ADDR_CLOCKING_4 = 8'h42;
	localparam int unsigned BIT_OSCILLATOR_ENABLE     = 3;
	localparam int unsigned BIT_TO_HALF     = 15;
	localparam int unsigned BIT_TO_ENA      = 14;
	localparam int unsigned BIT_TO_DIV16    = 8;
	localparam int unsigned BIT_TO_X4       = 7;
	localparam logic        RST_OSCILLATOR_ENABLE     = 1'b0;
	localparam logic        RST_TO_ENA      = 1'b0;
	localparam logic        RST_TO_HALF     = 1'b0;
	localparam logic        RST_TO_X4       = 1'b0;
	localparam logic        RST_TO_DIV16    = 1'b0;
	localparam int unsigned SHIFT_NO_X4     = 2;
	localparam int unsigned SHIFT_HALF      = 1;
	localparam int unsigned SHIFT_DIV16     = 4;
endpackage
`default_nettype wire

// ### hw/tcgen_div_if.sv
// Carrier between the top and a tick divider
`timescale 1ns/1ns
`default_nettype none
interface tcgen_div_if #(parameter int unsigned W = 20);
	logic         step;
	logic         clear;
	logic [W-1:0] period;
	logic         wrap;
	logic         half;
	modport ctl (output step, output clear, output period, input wrap, input half);
	modport div (input step, input clear, input period, output wrap, output half);
endinterface
`default_nettype wire

// ### hw/tcgen_div.sv
// Tick divider: counts steps, pulses at wrap, gives first-half level
`timescale 1ns/1ns
`default_nettype none
module tcgen_div #(
	parameter int unsigned W = 20
) (
	input  wire logic clk_in,
	input  wire logic rst_n_in,
	tcgen_div_if.div  d
);
	logic [W-1:0] count_q;
	logic         last;

	assign last = (count_q == d.period - W'(1));

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			count_q <= '0;
		end else if (d.clear) begin
			count_q <= '0;
		end else if (d.step) begin
			count_q <= last ? '0 : count_q + W'(1);
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			d.wrap <= 1'b0;
		end else begin
			d.wrap <= d.step && !d.clear && last;
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			d.half <= 1'b1;
		end else begin
			d.half <= d.clear || (count_q < (d.period >> 1));
		end
	end
endmodule
`default_nettype wire

// ### tb/tcgen_top_tb.sv
// Self-checking bench for the timeout clock generator
`timescale 1ns/1ns
`default_nettype none
module tcgen_top_tb;
	import tcgen_pkg::*;
	logic        clk_in = 1'b0;
	logic        rst_n_in = 1'b0;
	logic [7:0]  reg_addr_in = 8'h00;
	logic [15:0] reg_wdata_in = 16'h0000;
	logic        reg_wr_in = 1'b0;
	logic        reg_rd_in = 1'b0;
	logic        update_pending_in = 1'b0;
	logic        zero_cross_in = 1'b0;
	logic [15:0] reg_rdata_out;
	logic        system_clock_out;
	logic        timeout_clock_out;
	logic        timeout_tick_out;
	logic        update_apply_out;
	int          n_errors = 0;
	int          n_tests = 0;
	localparam int TB_BASE = 4;
	tcgen_top #(.TO_BASE(TB_BASE)) tcgen_top_i (.clk_in(clk_in), .rst_n_in(rst_n_in), .reg_addr_in(reg_addr_in),
		.reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
		.update_pending_in(update_pending_in), .zero_cross_in(zero_cross_in), .reg_rdata_out(reg_rdata_out),
		.system_clock_out(system_clock_out), .timeout_clock_out(timeout_clock_out),
		.timeout_tick_out(timeout_tick_out), .update_apply_out(update_apply_out));
	always #5 clk_in = ~clk_in;
	task automatic end_of_test;
		if (n_errors == 0 && n_tests > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp) begin
			n_errors++;
			$display("Error %s expected %0h seen %0h", what, exp, got);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk_in);
		reg_addr_in <= a;
		reg_wdata_in <= d;
		reg_wr_in <= 1'b1;
		@(posedge clk_in);
		reg_wr_in <= 1'b0;
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
		@(posedge clk_in);
		reg_addr_in <= a;
		reg_rd_in <= 1'b1;
		@(posedge clk_in);
		reg_rd_in <= 1'b0;
		@(posedge clk_in);
		#1 chk("reg_rdata_out", exp, reg_rdata_out);
	endtask
	// Cycles until the next tick, bounded
	task automatic wait_tick(output int n);
		for (n = 1; n < 20000; n++) begin
			@(posedge clk_in);
			#1;
			if (timeout_tick_out === 1'b1) break;
		end
		chk("timeout_tick_out", 1, timeout_tick_out);
	endtask
	// Counts high cycles of both clocks over a span, timeout tick cycles counted with the timeout clock
	task automatic count_hi(input int span, output int s, output int t);
		s = 0;
		t = 0;
		repeat (span) begin
			@(posedge clk_in);
			#1;
			s += (system_clock_out !== 1'b0);
			t += (timeout_clock_out !== 1'b0) || (timeout_tick_out !== 1'b0);
		end
	endtask
	task automatic t_regs;
		rd_chk(ADDR_PWR_MGMT_1, 16'h0000);
		rd_chk(ADDR_CLOCKING_1, 16'h0000);
		rd_chk(ADDR_CLOCKING_4, 16'h0000);
		wr(ADDR_CLOCKING_4, 16'hFFFF);
		rd_chk(ADDR_CLOCKING_4, 16'h0180);
		wr(ADDR_CLOCKING_1, 16'hFFFF);
		rd_chk(ADDR_CLOCKING_1, 16'hC000);
		wr(8'h10, 16'hFFFF);
		rd_chk(8'h10, 16'h0000);
		wr(ADDR_CLOCKING_1, 16'h0000);
		wr(ADDR_CLOCKING_4, 16'h0000);
	endtask
	task automatic t_osc;
		int s;
		int t;
		count_hi(60, s, t);
		chk("system_clock_out high while off", 0, s);
		wr(ADDR_PWR_MGMT_1, 16'h0008);
		// Divider held in clear keeps half high, so the first high phase is one cycle longer
		count_hi(10 * SYS_DIV, s, t);
		chk("system_clock_out high cycles", 10 * (SYS_DIV / 2) + 1, s);
		chk("timeout_clock_out with its enable clear", 0, t);
		wr(ADDR_PWR_MGMT_1, 16'h0000);
		wr(ADDR_CLOCKING_1, 16'hC000);
		count_hi(300, s, t);
		chk("system_clock_out after disable", 0, s);
		chk("timeout_clock_out with osc off", 0, t);
	endtask
	task automatic t_rates;
		int n;
		int shift;
		for (int i = 0; i < 8; i++) begin
			wr(ADDR_CLOCKING_1, {i[2], 1'b1, 14'h0000});
			wr(ADDR_CLOCKING_4, {7'h00, i[0], i[1], 7'h00});
			wr(ADDR_PWR_MGMT_1, 16'h0008);
			shift = (i[1] ? 0 : 2) + (i[2] ? 0 : 1) + (i[0] ? 4 : 0);
			wait_tick(n);
			wait_tick(n);
			wait_tick(n);
			chk("timeout period in clk cycles", (TB_BASE << shift) * SYS_DIV, n);
		end
	endtask
	// Rate left by the last loop: all three bits set, period 16 base ticks
	task automatic t_apply;
		int n;
		int s;
		int t;
		@(posedge clk_in);
		update_pending_in <= 1'b1;
		wait_tick(n);
		chk("update_apply_out at timeout", 1, update_apply_out);
		// One full period from a tick: first half high, plus the closing tick
		count_hi(16 * TB_BASE * SYS_DIV, s, t);
		chk("timeout_clock_out high cycles", 8 * TB_BASE * SYS_DIV + 1, t);
		chk("system_clock_out high cycles per period", 16 * TB_BASE * (SYS_DIV / 2), s);
		@(posedge clk_in);
		zero_cross_in <= 1'b1;
		@(posedge clk_in);
		zero_cross_in <= 1'b0;
		#1 chk("update_apply_out at zero cross", 1, update_apply_out);
		@(posedge clk_in);
		update_pending_in <= 1'b0;
		zero_cross_in <= 1'b1;
		@(posedge clk_in);
		zero_cross_in <= 1'b0;
		#1 chk("update_apply_out without pending", 0, update_apply_out);
	endtask
	initial begin
		#800_000;
		n_errors++;
		end_of_test();
	end
	initial begin
		repeat (10) @(posedge clk_in);
		rst_n_in <= 1'b1;
		t_regs();
		t_osc();
		wr(ADDR_CLOCKING_1, 16'h0000);
		t_rates();
		t_apply();
		end_of_test();
	end
endmodule
`default_nettype wire
